// *** include/usb_xcvr_defs.svh ***
`ifndef USB_XCVR_DEFS_SVH
`define USB_XCVR_DEFS_SVH

// ****************************************************************
// register address, fields and reset value
// ****************************************************************
`define XCVR_CTRL_ADDR      8'hD7
`define XCVR_CTRL_RESET     8'h00
`define BIT_PULLUP_EN       7
`define BIT_XCVR_ON         6
`define BIT_SPEED           5
`define BIT_TEST_HI         4
`define BIT_TEST_LO         3
`define BIT_DIFF_RX         2
`define BIT_POS_LEVEL       1
`define BIT_NEG_LEVEL       0
`define WRITABLE_MASK       8'hF8

// ****************************************************************
// endpoint addressing
// ****************************************************************
`define EP0_ADDR            8'h00
`define EP1_IN_ADDR         8'h81
`define EP1_OUT_ADDR        8'h01
`define EP1_IN_BYTES        64
`define EP1_OUT_BYTES       128
`define PIPE_COUNT          3

`endif

// *** include/usb_xcvr_pkg.sv ***
package usb_xcvr_pkg;

    // line test drive selection
    typedef enum logic [1:0] {
        test_normal    = 2'h0,
        test_diff_one  = 2'h1,
        test_diff_zero = 2'h2,
        test_se_zero   = 2'h3
    } line_test_type;

    // pipe selected by an endpoint address
    typedef enum logic [1:0] {
        pipe_control,
        pipe_ep1_in,
        pipe_ep1_out,
        pipe_none
    } pipe_type;

endpackage

// *** rtl/endpoint_decode.sv ***
`timescale 1ns/10ps
`include "usb_xcvr_defs.svh"

// ****************************************************************
// maps a token endpoint address and direction onto one of three pipes
// ****************************************************************
module endpoint_decode (
    input  wire logic                  ref_clk,
    input  wire logic                  rstn,
    input  wire logic                  token_valid,
    input  wire logic [7:0]            token_ep_addr,
    output usb_xcvr_pkg::pipe_type     pipe_sel,
    output logic                       pipe_hit
);
    import usb_xcvr_pkg::*;

    pipe_type next_pipe;

    // direction bit 7 set means IN
    always_comb begin
        if (token_ep_addr[3:0] == `EP0_ADDR) begin
            next_pipe = pipe_control;
        end else if (token_ep_addr == `EP1_IN_ADDR) begin
            next_pipe = pipe_ep1_in;
        end else if (token_ep_addr == `EP1_OUT_ADDR) begin
            next_pipe = pipe_ep1_out;
        end else begin
            next_pipe = pipe_none;
        end
    end

    // registered decode result
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pipe_sel <= pipe_none;
            pipe_hit <= 1'b0;
        end else begin
            pipe_sel <= next_pipe;
            pipe_hit <= token_valid && (next_pipe != pipe_none);
        end
    end
endmodule

// *** rtl/line_sync.sv ***
`timescale 1ns/10ps

// ****************************************************************
// three-stage synchroniser, change taken when stages two and three agree
// ****************************************************************
module line_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             ref_clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // a zero-width chain has nothing to carry
    if (WIDTH < 1) begin : g_bad_width
        $error("line_sync width must be positive");
    end

    // shift chain; stage1 only feeds stage2
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // per bit, accept a new level only when two stages agree
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    sync_out[i] <= 1'b0;
                end else if (stage2[i] == stage3[i]) begin
                    sync_out[i] <= stage3[i];
                end
            end
        end
    endgenerate
endmodule

// *** rtl/usb_transceiver_control.sv ***
`timescale 1ns/10ps
`include "usb_xcvr_defs.svh"

// Notes on behaviour
// - With speed select one the function runs full speed and the pullup goes on D+.
// - With speed select zero the function runs low speed and the pullup goes on D-.
// - With pullup enable zero the attach pullup stays off and the device looks detached.
// - The pullup is on only while pullup enable is one and bus power is present.
// - Transceiver enable zero suspends the transceiver, one runs it normally.
// - The line test field forces 01 D+ high D- low, 10 D+ low D- high, 11 both low.
// - While the transceiver is on, the differential bit shows the bus differential value.
// - The positive line bit shows the live D+ level.
// - The negative line bit shows the live D- level.
// - Endpoint zero answers IN and OUT at address 0x00 as the control pipe.
// - Endpoint one has a 64-byte IN pipe at 0x81 and a 128-byte OUT pipe at 0x01.
// - The block is a peripheral only and never issues tokens or frames.
// - Exactly three pipes exist: control, endpoint one IN, endpoint one OUT.
module usb_transceiver_control (
    input  wire logic                  ref_clk,
    input  wire logic                  rstn,
    // special function register port
    input  wire logic [7:0]            sfr_addr,
    input  wire logic                  sfr_wr,
    input  wire logic                  sfr_rd,
    input  wire logic [7:0]            sfr_wdata,
    output logic      [7:0]            sfr_rdata,
    output logic                       sfr_hit,
    // bus power and line pins
    input  wire logic                  vbus_present,
    input  wire logic                  dp_in,
    input  wire logic                  dn_in,
    output logic                       dp_out,
    output logic                       dp_oe_n,
    output logic                       dn_out,
    output logic                       dn_oe_n,
    // function core side
    input  wire logic                  core_tx_en,
    input  wire logic                  core_tx_dp,
    input  wire logic                  core_tx_dn,
    output logic                       pullup_dp,
    output logic                       pullup_dn,
    output logic                       transceiver_on,
    output logic                       transceiver_suspend,
    output logic                       full_speed,
    output logic                       rx_diff,
    // token endpoint lookup
    input  wire logic                  token_valid,
    input  wire logic [7:0]            token_ep_addr,
    output usb_xcvr_pkg::pipe_type     pipe_sel,
    output logic                       pipe_hit
);
    import usb_xcvr_pkg::*;

    // ****************************************************************
    // reset values and layout checks
    // ****************************************************************
    localparam logic [7:0] CTRL_RESET   = `XCVR_CTRL_RESET;
    localparam logic [7:0] CTRL_WRITE   = `WRITABLE_MASK;
    localparam logic       RESET_PULLUP = CTRL_RESET[`BIT_PULLUP_EN];
    localparam logic       RESET_XCVR   = CTRL_RESET[`BIT_XCVR_ON];
    localparam logic       RESET_SPEED  = CTRL_RESET[`BIT_SPEED];
    localparam logic [1:0] RESET_TEST   = CTRL_RESET[`BIT_TEST_HI:`BIT_TEST_LO];

    // the read path packs the fields in one fixed order; refuse a header
    // whose field positions have drifted from that order
    if (`BIT_XCVR_ON != `BIT_PULLUP_EN - 1 || `BIT_SPEED != `BIT_XCVR_ON - 1 ||
        `BIT_TEST_HI != `BIT_SPEED - 1 || `BIT_TEST_LO != `BIT_TEST_HI - 1) begin : g_bad_ctrl
        $error("control fields out of read order");
    end
    if (`BIT_DIFF_RX != `BIT_TEST_LO - 1 || `BIT_POS_LEVEL != `BIT_DIFF_RX - 1 ||
        `BIT_NEG_LEVEL != `BIT_POS_LEVEL - 1) begin : g_bad_status
        $error("status fields out of read order");
    end
    if (`BIT_PULLUP_EN != $bits(CTRL_RESET) - 1 || `BIT_NEG_LEVEL != 0) begin : g_bad_span
        $error("control register fields do not span the byte");
    end
    // a writable status position would let firmware fake line levels
    if (CTRL_WRITE[`BIT_DIFF_RX:`BIT_NEG_LEVEL] != 3'h0) begin : g_bad_mask
        $error("status bits marked writable");
    end

    // ****************************************************************
    // control register
    // ****************************************************************
    logic          attach_pullup_enable;
    logic          speed_full;
    line_test_type line_test_select;
    logic [2:0]    line_sync_out;
    logic          positive_line_level;
    logic          negative_line_level;
    logic          diff_receiver_state;
    logic          reg_sel;
    logic          pullup_on;
    logic [7:0]    next_rdata;
    logic          next_hit;
    logic          reg_write;
    logic [7:0]    write_fields;
    logic          next_pullup_dp;
    logic          next_pullup_dn;

    // address decode for the one register of this block
    always_comb begin
        if (sfr_addr == `XCVR_CTRL_ADDR) begin
            reg_sel = 1'b1;
        end else begin
            reg_sel = 1'b0;
        end
    end

    // status positions are masked off, so a write can never reach them
    assign reg_write    = sfr_wr && reg_sel;
    assign write_fields = sfr_wdata & CTRL_WRITE;

    // one write strobe updates all writable fields together
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            attach_pullup_enable <= RESET_PULLUP;
            transceiver_on       <= RESET_XCVR;
            speed_full           <= RESET_SPEED;
            line_test_select     <= line_test_type'(RESET_TEST);
        end else if (reg_write) begin
            attach_pullup_enable <= write_fields[`BIT_PULLUP_EN];
            transceiver_on       <= write_fields[`BIT_XCVR_ON];
            speed_full           <= write_fields[`BIT_SPEED];
            line_test_select     <= line_test_type'(write_fields[`BIT_TEST_HI:`BIT_TEST_LO]);
        end
    end

    // ****************************************************************
    // line level sampling
    // ****************************************************************
    line_sync #(
        .WIDTH (3)
    ) u_line_sync (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .async_in ({vbus_present, dp_in, dn_in}),
        .sync_out (line_sync_out)
    );

    assign positive_line_level = line_sync_out[1];
    assign negative_line_level = line_sync_out[0];
    assign pullup_on = attach_pullup_enable && line_sync_out[2];

    // speed picks the line that carries the pullup; both stay off while detached
    always_comb begin
        next_pullup_dp = 1'b0;
        next_pullup_dn = 1'b0;
        if (pullup_on && speed_full) begin
            next_pullup_dp = 1'b1;
        end else if (pullup_on) begin
            next_pullup_dn = 1'b1;
        end
    end

    // differential value only meaningful while transceiver runs
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            diff_receiver_state <= 1'b0;
        end else if (transceiver_on) begin
            diff_receiver_state <= positive_line_level && !negative_line_level;
        end
    end

    // ****************************************************************
    // register read
    // ****************************************************************
    // read data is zero unless this register is read; fields in register order
    always_comb begin
        next_rdata = 8'h00;
        next_hit   = 1'b0;
        if (reg_sel && sfr_rd) begin
            next_rdata = {attach_pullup_enable, transceiver_on, speed_full, line_test_select,
                          diff_receiver_state, positive_line_level, negative_line_level};
            next_hit   = 1'b1;
        end else if (reg_sel && sfr_wr) begin
            next_hit   = 1'b1;
        end
    end

    // answer is registered and stands for one cycle
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sfr_rdata <= 8'h00;
            sfr_hit   <= 1'b0;
        end else begin
            sfr_rdata <= next_rdata;
            sfr_hit   <= next_hit;
        end
    end

    // ****************************************************************
    // pullup placement and mode outputs
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pullup_dp           <= 1'b0;
            pullup_dn           <= 1'b0;
            full_speed          <= 1'b0;
            transceiver_suspend <= 1'b1;
            rx_diff             <= 1'b0;
        end else begin
            pullup_dp           <= next_pullup_dp;
            pullup_dn           <= next_pullup_dn;
            full_speed          <= speed_full;
            transceiver_suspend <= !transceiver_on;
            rx_diff             <= diff_receiver_state;
        end
    end

    // ****************************************************************
    // line drivers; enables are active low
    // ****************************************************************
    logic          core_drive;
    logic          next_dp_out;
    logic          next_dn_out;
    logic          next_oe_n;

    // outside test modes the core drives only while the transceiver runs;
    // a suspended transceiver must leave the lines to the host
    assign core_drive = core_tx_en && transceiver_on;

    // forced test states win over the core; both lines switch together
    always_comb begin
        next_dp_out = core_tx_dp;
        next_dn_out = core_tx_dn;
        next_oe_n   = !core_drive;
        case (line_test_select)
            test_diff_one: begin
                next_dp_out = 1'b1;
                next_dn_out = 1'b0;
                next_oe_n   = 1'b0;
            end
            test_diff_zero: begin
                next_dp_out = 1'b0;
                next_dn_out = 1'b1;
                next_oe_n   = 1'b0;
            end
            test_se_zero: begin
                next_dp_out = 1'b0;
                next_dn_out = 1'b0;
                next_oe_n   = 1'b0;
            end
            default: begin
                next_dp_out = core_tx_dp;
                next_dn_out = core_tx_dn;
                next_oe_n   = !core_drive;
            end
        endcase
    end

    // pins come straight from flops and are released while in reset
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dp_out  <= 1'b0;
            dn_out  <= 1'b0;
            dp_oe_n <= 1'b1;
            dn_oe_n <= 1'b1;
        end else begin
            dp_out  <= next_dp_out;
            dn_out  <= next_dn_out;
            dp_oe_n <= next_oe_n;
            dn_oe_n <= next_oe_n;
        end
    end

    // ****************************************************************
    // endpoint pipe lookup
    // ****************************************************************
    endpoint_decode u_endpoint_decode (
        .ref_clk       (ref_clk),
        .rstn          (rstn),
        .token_valid   (token_valid),
        .token_ep_addr (token_ep_addr),
        .pipe_sel      (pipe_sel),
        .pipe_hit      (pipe_hit)
    );
endmodule

// *** tb/usb_host_model.sv ***
`timescale 1ns/10ps
// ********
// host side of the line pair
// ********
module usb_host_model (
    input  wire logic host_drive,
    input  wire logic host_dp,
    input  wire logic host_dn,
    input  wire logic dp_out,
    input  wire logic dp_oe_n,
    input  wire logic dn_out,
    input  wire logic dn_oe_n,
    input  wire logic pullup_dp,
    input  wire logic pullup_dn,
    output logic      dp_in,
    output logic      dn_in
);
    // device drive wins, then host; idle lines sit at the pull level
    always_comb begin
        dp_in = !dp_oe_n ? dp_out : (host_drive ? host_dp : pullup_dp);
        dn_in = !dn_oe_n ? dn_out : (host_drive ? host_dn : pullup_dn);
    end
endmodule

// *** tb/usb_transceiver_control_monitor.sv ***
`timescale 1ns/10ps
// ********
// port checks
// ********
module usb_transceiver_control_monitor (
    input  wire logic                   ref_clk,
    input  wire logic                   rstn,
    input  wire logic                   sfr_rd,
    input  wire logic                   sfr_wr,
    input  wire logic [7:0]             sfr_addr,
    input  wire logic [7:0]             sfr_rdata,
    input  wire logic                   sfr_hit,
    input  wire logic                   token_valid,
    input  wire logic [7:0]             token_ep_addr,
    input  wire usb_xcvr_pkg::pipe_type pipe_sel,
    input  wire logic                   pipe_hit,
    input  wire logic                   pullup_dp,
    input  wire logic                   pullup_dn,
    input  wire logic                   full_speed,
    input  wire logic                   transceiver_on,
    input  wire logic                   transceiver_suspend,
    input  wire logic                   dp_oe_n,
    input  wire logic                   dn_oe_n
);
    import usb_xcvr_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // pullup placement and power state
    one_pullup_a: assert property (!(pullup_dp && pullup_dn))
        else $error("pullups on both lines");
    dp_pull_speed_a: assert property (pullup_dp |-> full_speed)
        else $error("dp pullup at low speed");
    dn_pull_speed_a: assert property (pullup_dn |-> !full_speed)
        else $error("dn pullup at full speed");
    suspend_state_a: assert property (transceiver_suspend == !$past(transceiver_on))
        else $error("suspend not inverse of enable");
    oe_paired_a: assert property (dp_oe_n == dn_oe_n)
        else $error("line drivers enabled apart");
    // register access
    read_hit_a: assert property (sfr_rd && sfr_addr == 8'hD7 |=> sfr_hit)
        else $error("read of control register missed");
    write_hit_a: assert property (sfr_wr && sfr_addr == 8'hD7 |=> sfr_hit)
        else $error("write of control register missed");
    read_miss_a: assert property (!sfr_rd && !sfr_wr |=> sfr_rdata == 8'h00 && !sfr_hit)
        else $error("hit without access");
    rdata_idle_a: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
        else $error("read data without read");
    // endpoint lookup
    ep_control_a: assert property (token_valid && token_ep_addr[6:0] == 7'h00 |=>
        pipe_sel == pipe_control && pipe_hit) else $error("endpoint zero not control");
    ep_in_a: assert property (token_valid && token_ep_addr == 8'h81 |=>
        pipe_sel == pipe_ep1_in && pipe_hit) else $error("endpoint one in missed");
    ep_out_a: assert property (token_valid && token_ep_addr == 8'h01 |=>
        pipe_sel == pipe_ep1_out && pipe_hit) else $error("endpoint one out missed");
    no_token_a: assert property (!token_valid |=> !pipe_hit)
        else $error("pipe hit without token");
    cover property (pullup_dp);
    cover property (pullup_dn);
    cover property (pipe_hit && pipe_sel == pipe_ep1_out);
endmodule

bind usb_transceiver_control usb_transceiver_control_monitor u_mon (.ref_clk, .rstn,
    .sfr_rd, .sfr_wr, .sfr_addr, .sfr_rdata, .sfr_hit, .token_valid, .token_ep_addr,
    .pipe_sel, .pipe_hit,
    .pullup_dp, .pullup_dn, .full_speed, .transceiver_on, .transceiver_suspend, .dp_oe_n,
    .dn_oe_n);

// *** tb/usb_transceiver_control_test.sv ***
`timescale 1ns/10ps
// ********
// bench
// ********
module usb_transceiver_control_test;
    import usb_xcvr_pkg::*;
    logic       ref_clk = 0, rstn = 0, sfr_wr = 0, sfr_rd = 0, vbus_present = 0;
    logic [7:0] sfr_addr = 8'hD7, sfr_wdata = 8'h00, token_ep_addr = 8'h00, sfr_rdata, v;
    logic       core_tx_en = 0, core_tx_dp = 0, core_tx_dn = 0, token_valid = 0, h;
    logic       host_drive = 0, host_dp = 0, host_dn = 0, dp_in, dn_in, dp_out, dn_out;
    logic       dp_oe_n, dn_oe_n, pullup_dp, pullup_dn, sfr_hit, pipe_hit, rx_diff;
    pipe_type   pipe_sel;
    int         n_mismatch = 0, tests_run = 0, cycles = 0;

    // clock runs from time zero, well before the transceiver is enabled
    always #2.5 ref_clk = ~ref_clk;

    usb_transceiver_control u_dut (.ref_clk, .rstn, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
        .sfr_rdata, .sfr_hit, .vbus_present, .dp_in, .dn_in, .dp_out, .dp_oe_n, .dn_out,
        .dn_oe_n, .core_tx_en, .core_tx_dp, .core_tx_dn, .pullup_dp, .pullup_dn,
        .transceiver_on(), .transceiver_suspend(), .full_speed(), .rx_diff, .token_valid,
        .token_ep_addr, .pipe_sel, .pipe_hit);
    usb_host_model u_host (.host_drive, .host_dp, .host_dn, .dp_out, .dp_oe_n, .dn_out,
        .dn_oe_n, .pullup_dp, .pullup_dn, .dp_in, .dn_in);

    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic reg_wr(logic [7:0] d);
        @(negedge ref_clk);
        sfr_wdata = d;
        sfr_wr = 1;
        @(negedge ref_clk);
        sfr_wr = 0;
    endtask

    // read strobe for one cycle, answer taken at the following negedge
    task automatic reg_rd(logic [7:0] a);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_rd = 1;
        @(negedge ref_clk);
        sfr_rd = 0;
        sfr_addr = 8'hD7;
        v = sfr_rdata;
        h = sfr_hit;
    endtask

    task automatic reset_values;
        reg_rd(8'hD7);
        check("reset value", v, 8'h00);
        check("hit", h, 1);
        reg_rd(8'hD6);
        check("unmapped read", {h, v[6:0]}, 8'h00);
        check("pipe", {pipe_hit, pipe_sel}, {1'b0, pipe_control});
    endtask

    // entries: register value, bus power, expected pullup on dp, on dn
    task automatic pullup_cases;
        logic [10:0] t[4] = '{{8'hA0, 3'b110}, {8'h80, 3'b101}, {8'h80, 3'b000}, {8'h20, 3'b100}};
        for (int i = 0; i < 4; i++) begin
            reg_wr(t[i][10:3]);
            vbus_present = t[i][2];
            repeat (8) @(negedge ref_clk);
            check("pullup pair", {pullup_dp, pullup_dn}, t[i][1:0]);
            reg_rd(8'hD7);
            check("pulled lines", v, {t[i][10:3] & 8'hF8} | t[i][1:0]);
        end
    endtask

    task automatic status_bits;
        reg_wr(8'h47);
        for (int j = 0; j < 3; j++) begin
            host_drive = 1;
            host_dp = (j == 0);
            host_dn = (j == 1);
            repeat (8) @(negedge ref_clk);
            reg_rd(8'hD7);
            check("line status", v, {5'b01000, host_dp & !host_dn, host_dp, host_dn});
            check("rx diff", rx_diff, host_dp & !host_dn);
        end
        host_drive = 0;
    endtask

    task automatic line_tests;
        logic dpv, dnv;
        core_tx_en = 1;
        core_tx_dp = 1;
        for (int m = 0; m < 4; m++) begin
            dpv = (m < 2);
            dnv = (m == 2);
            reg_wr({3'b010, 2'(m), 3'b000});
            repeat (8) @(negedge ref_clk);
            check("drive", {dp_oe_n, dp_out, dn_out}, {1'b0, dpv, dnv});
            reg_rd(8'hD7);
            check("driven status", v, {3'b010, 2'(m), dpv & !dnv, dpv, dnv});
        end
        reg_wr(8'h00);
        repeat (2) @(negedge ref_clk);
        check("suspended drive", {dp_oe_n, dn_oe_n}, 2'b11);
        reg_wr(8'h40);
        core_tx_en = 0;
        repeat (2) @(negedge ref_clk);
        check("released", {dp_oe_n, dn_oe_n}, 2'b11);
    endtask

    // tokens back to back, one per cycle
    task automatic endpoints;
        logic [7:0] a[6] = '{8'h00, 8'h80, 8'h81, 8'h01, 8'h02, 8'h82};
        pipe_type   s[6] = '{pipe_control, pipe_control, pipe_ep1_in, pipe_ep1_out, pipe_none,
                             pipe_none};
        token_valid = 1;
        for (int i = 0; i < 6; i++) begin
            token_ep_addr = a[i];
            @(negedge ref_clk);
            check("pipe", {pipe_hit, pipe_sel}, {s[i] != pipe_none, s[i]});
        end
        token_valid = 0;
        token_ep_addr = 8'h81;
        @(negedge ref_clk);
        check("idle hit", pipe_hit, 0);
    endtask

    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            complete_run;
        end
    end

    // main sequence
    initial begin
        repeat (3) @(negedge ref_clk);
        rstn = 1;
        reset_values;
        pullup_cases;
        status_bits;
        line_tests;
        endpoints;
        complete_run;
    end
endmodule
